/* common/dpps_pkg.sv */
// package for the debug port pin sharing block: register map, fields and constants
package dpps_pkg;
	localparam int ADDR_W = 4;
	// register byte addresses
	localparam logic [3:0] OFS_MODE = 4'h0;
	localparam logic [3:0] OFS_PAD = 4'h4;
	localparam logic [3:0] OFS_STATUS = 4'h8;
	localparam logic [3:0] OFS_GPIO = 4'hC;
	// shared pin indexes within the mode register
	localparam int PIN_TDI = 0;
	localparam int PIN_TDO = 1;
	localparam int PIN_TMS = 2;
	localparam int PIN_TCK = 3;
	localparam int PIN_ERASE = 4;
	localparam int NPIN = 5;
	localparam logic [4:0] MODE_RST = 5'h00;
	// pad field positions in the pad register, four bits per pin
	localparam int PAD_PULLUP = 0;
	localparam int PAD_TRIG = 1;
	localparam int PAD_DEBOUNCE = 2;
	localparam int PAD_GLITCH = 3;
	localparam int PAD_FW = 4;
	localparam logic [19:0] PAD_RST = 20'h11111;
	// status bit positions
	localparam int ST_SWD = 0;
	localparam int ST_SCAN = 1;
	localparam int ST_ERASE = 2;
	// switch sequence: 16 bits on tms, lsb first, preceded by 50 high
	localparam logic [15:0] SWITCH_SEQ = 16'hE79E;
	localparam int SWITCH_LEN = 16;
	localparam int LINE_RESET_LEN = 50;
	// debounce filter length in cycles
	localparam logic [3:0] DEBOUNCE_CYC = 4'hF;
endpackage

/* rtl/dpps_top.sv */
// debug port pin sharing: debug/gpio mux, pad settings, scan select and swd switch
//
// Register access over Avalon-MM and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
// Functional notes
// - after reset every shared debug pin is in its debug function.
// - software moves each pin to general purpose io through the mode register.
// - pull-up, trigger, debounce and glitch settings act in both pin modes.
// - a high scan select enters boundary scan, low or open runs normally.
// - the scan port is active by default and the probe's tms sequence selects serial wire.
// - async trace drives the tdo pin only while the serial wire port is active.
module dpps_top (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [4:0] pad_in,
	output logic [4:0] pad_out,
	output logic [4:0] pad_oe,
	output logic [4:0] pad_pullup,
	output logic [4:0] pad_schmitt,
	input wire logic boundary_scan_select,
	input wire logic dbg_tdo,
	input wire logic dbg_tdo_oe,
	input wire logic dbg_swdio_out,
	input wire logic dbg_swdio_oe,
	input wire logic async_trace_out,
	output logic [4:0] dbg_pin_in,
	output logic serial_wire_port_on,
	output logic scan_mode_on,
	output logic erase_request
);
	logic [4:0] mode_ff;
	logic [19:0] pad_ff;
	logic [4:0] gp_out_ff;
	logic [4:0] gp_oe_ff;
	logic [4:0] sync1_ff;
	logic [4:0] sync2_ff;
	logic [4:0] filt_ff;
	logic [3:0] deb_cnt_ff [5];
	logic [4:0] glitch_ff;
	logic scan1_ff;
	logic scan2_ff;
	logic swd_ff;
	logic [5:0] high_cnt_ff;
	logic [15:0] seq_ff;
	logic [4:0] seq_cnt_ff;
	logic tck_d_ff;
	logic start1_ff;
	logic start2_ff;
	logic started_ff;
	logic erase_ff;
	logic ack_ff;
	logic [4:0] nxt_out;
	logic [4:0] nxt_oe;
	logic [31:0] nxt_rdata;
	logic access;
	logic tck_rise;
	logic tms;

	assign access = (avs_read | avs_write) & ~ack_ff;
	assign tms = filt_ff[dpps_pkg::PIN_TMS];
	assign tck_rise = filt_ff[dpps_pkg::PIN_TCK] & ~tck_d_ff;

	// register slave: one wait cycle, answer on the second edge
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= access;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			mode_ff <= dpps_pkg::MODE_RST;
			pad_ff <= dpps_pkg::PAD_RST;
			gp_out_ff <= 5'h00;
			gp_oe_ff <= 5'h00;
		end else if (ack_ff && avs_write) begin
			unique case (avs_address)
				dpps_pkg::OFS_MODE: mode_ff <= avs_writedata[4:0];
				dpps_pkg::OFS_PAD: pad_ff <= avs_writedata[19:0];
				dpps_pkg::OFS_GPIO: begin
					gp_out_ff <= avs_writedata[4:0];
					gp_oe_ff <= avs_writedata[12:8];
				end
				default: ;
			endcase
		end
	end

	always_comb begin
		nxt_rdata = 32'h00000000;
		unique case (avs_address)
			dpps_pkg::OFS_MODE: nxt_rdata[4:0] = mode_ff;
			dpps_pkg::OFS_PAD: nxt_rdata[19:0] = pad_ff;
			dpps_pkg::OFS_STATUS: begin
				nxt_rdata[dpps_pkg::ST_SWD] = swd_ff;
				nxt_rdata[dpps_pkg::ST_SCAN] = scan2_ff;
				nxt_rdata[dpps_pkg::ST_ERASE] = erase_ff;
			end
			dpps_pkg::OFS_GPIO: nxt_rdata = {11'h000, filt_ff, 3'h0, gp_oe_ff, 3'h0, gp_out_ff};
			default: ;
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			avs_readdata <= 32'h00000000;
		end else if (access && avs_read) begin
			avs_readdata <= nxt_rdata;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= ~access;
		end
	end

	// pin input synchronisers
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_ff <= 5'h00;
			sync2_ff <= 5'h00;
			scan1_ff <= 1'b0;
			scan2_ff <= 1'b0;
		end else begin
			sync1_ff <= pad_in;
			sync2_ff <= sync1_ff;
			scan1_ff <= boundary_scan_select;
			scan2_ff <= scan1_ff;
		end
	end

	// input conditioning applies regardless of the pin mode
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			glitch_ff <= 5'h00;
			filt_ff <= 5'h00;
			for (int i = 0; i < dpps_pkg::NPIN; i++) begin
				deb_cnt_ff[i] <= 4'h0;
			end
		end else begin
			glitch_ff <= sync2_ff;
			for (int i = 0; i < dpps_pkg::NPIN; i++) begin
				if (pad_ff[i*dpps_pkg::PAD_FW+dpps_pkg::PAD_DEBOUNCE]) begin
					if (sync2_ff[i] == filt_ff[i]) begin
						deb_cnt_ff[i] <= 4'h0;
					end else if (deb_cnt_ff[i] == dpps_pkg::DEBOUNCE_CYC) begin
						deb_cnt_ff[i] <= 4'h0;
						filt_ff[i] <= sync2_ff[i];
					end else begin
						deb_cnt_ff[i] <= deb_cnt_ff[i] + 4'h1;
					end
				end else if (pad_ff[i*dpps_pkg::PAD_FW+dpps_pkg::PAD_GLITCH]) begin
					deb_cnt_ff[i] <= 4'h0;
					if (sync2_ff[i] == glitch_ff[i]) begin
						filt_ff[i] <= sync2_ff[i];
					end
				end else begin
					deb_cnt_ff[i] <= 4'h0;
					filt_ff[i] <= sync2_ff[i];
				end
			end
		end
	end

	// scan to serial wire switch, watched on tck rising edges
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			tck_d_ff <= 1'b0;
			high_cnt_ff <= 6'h00;
			seq_ff <= 16'h0000;
			seq_cnt_ff <= 5'h00;
			swd_ff <= 1'b0;
		end else begin
			tck_d_ff <= filt_ff[dpps_pkg::PIN_TCK];
			if (scan2_ff || mode_ff[dpps_pkg::PIN_TCK] || mode_ff[dpps_pkg::PIN_TMS]) begin
				high_cnt_ff <= 6'h00;
				seq_cnt_ff <= 5'h00;
				swd_ff <= 1'b0;
			end else if (tck_rise) begin
				if (tms && high_cnt_ff != dpps_pkg::LINE_RESET_LEN[5:0]) begin
					high_cnt_ff <= high_cnt_ff + 6'h01;
				end
				if (high_cnt_ff == dpps_pkg::LINE_RESET_LEN[5:0]
						&& seq_cnt_ff != dpps_pkg::SWITCH_LEN[4:0]) begin
					if (tms == dpps_pkg::SWITCH_SEQ[seq_cnt_ff[3:0]]) begin
						seq_cnt_ff <= seq_cnt_ff + 5'h01;
						if (seq_cnt_ff == 5'(dpps_pkg::SWITCH_LEN - 1)) begin
							swd_ff <= 1'b1;
							high_cnt_ff <= 6'h00;
						end
					end else if (!tms) begin
						seq_cnt_ff <= 5'h00;
						high_cnt_ff <= 6'h00;
					end
				end
			end
		end
	end

	// erase pin level caught once, after the synchroniser holds the pin and not its reset value
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			start1_ff <= 1'b0;
			start2_ff <= 1'b0;
			started_ff <= 1'b0;
			erase_ff <= 1'b0;
		end else begin
			start1_ff <= 1'b1;
			start2_ff <= start1_ff;
			if (start2_ff && !started_ff) begin
				started_ff <= 1'b1;
				erase_ff <= sync2_ff[dpps_pkg::PIN_ERASE] & ~mode_ff[dpps_pkg::PIN_ERASE];
			end
		end
	end

	// output mux: debug function unless the pin's mode bit selects gpio
	always_comb begin
		nxt_out = gp_out_ff;
		nxt_oe = gp_oe_ff & mode_ff;
		if (!mode_ff[dpps_pkg::PIN_TDO]) begin
			nxt_out[dpps_pkg::PIN_TDO] = swd_ff ? async_trace_out : dbg_tdo;
			nxt_oe[dpps_pkg::PIN_TDO] = swd_ff ? 1'b1 : dbg_tdo_oe;
		end
		if (!mode_ff[dpps_pkg::PIN_TMS]) begin
			nxt_out[dpps_pkg::PIN_TMS] = dbg_swdio_out;
			nxt_oe[dpps_pkg::PIN_TMS] = swd_ff & dbg_swdio_oe;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pad_out <= 5'h00;
			pad_oe <= 5'h00;
			pad_pullup <= 5'h1F;
			pad_schmitt <= 5'h00;
			dbg_pin_in <= 5'h00;
			serial_wire_port_on <= 1'b0;
			scan_mode_on <= 1'b0;
			erase_request <= 1'b0;
		end else begin
			pad_out <= nxt_out;
			pad_oe <= nxt_oe;
			for (int i = 0; i < dpps_pkg::NPIN; i++) begin
				pad_pullup[i] <= pad_ff[i*dpps_pkg::PAD_FW+dpps_pkg::PAD_PULLUP];
				pad_schmitt[i] <= pad_ff[i*dpps_pkg::PAD_FW+dpps_pkg::PAD_TRIG];
			end
			dbg_pin_in <= filt_ff & ~mode_ff;
			serial_wire_port_on <= swd_ff;
			scan_mode_on <= scan2_ff;
			erase_request <= erase_ff;
		end
	end
endmodule

/* tb/dpps_sva.sv */
// checker for bus handshake, scan select, port switch and erase latch
`timescale 1ns/1ns
module dpps_sva (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic boundary_scan_select,
	input wire logic serial_wire_port_on,
	input wire logic scan_mode_on,
	input wire logic erase_request
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=>
		!avs_waitrequest) else $error("no answer to request");
	a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("answer too long");
	a_wait_cause: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
		else $error("answer without request");
	a_scan_enter: assert property (boundary_scan_select |-> ##[1:6] scan_mode_on)
		else $error("scan not entered");
	a_scan_leave: assert property (!boundary_scan_select [*6] |-> !scan_mode_on)
		else $error("scan without select");
	a_scan_swd: assert property (boundary_scan_select [*6] |-> !serial_wire_port_on)
		else $error("serial wire during scan");
	a_erase_hold: assert property ($past(arst_n, 5) |-> $stable(erase_request))
		else $error("erase changed after start");
	a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data moved");
	cover property ($rose(serial_wire_port_on));
	cover property ($rose(scan_mode_on));
	cover property (avs_write && !avs_waitrequest);
endmodule
bind dpps_top dpps_sva u_dpps_sva (.mclk, .arst_n, .avs_read, .avs_write, .avs_readdata,
	.avs_waitrequest, .boundary_scan_select, .serial_wire_port_on, .scan_mode_on, .erase_request);

/* tb/dpps_probe.sv */
// debug probe model driving the tck and tms pins
`timescale 1ns/1ns
module dpps_probe (
	input wire logic mclk,
	output logic tck,
	output logic tms
);
	// clock stands still low between frames
	initial begin
		tck = 1'b0;
		tms = 1'b1;
	end
	// 50 high bits then the given word lsb first
	task automatic send(input logic [15:0] seq);
		logic [65:0] v;
		v = {seq, {50{1'b1}}};
		for (int i = 0; i < 66; i++) begin
			tms <= v[i];
			repeat (4) @(posedge mclk);
			tck <= 1'b1;
			repeat (4) @(posedge mclk);
			tck <= 1'b0;
		end
	endtask
endmodule

/* tb/dpps_tb_top.sv */
// testbench for the debug pin sharing block
`timescale 1ns/1ns
module dpps_tb_top;
	logic mclk = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata;
	logic [4:0] pad_in, pad_out, pad_oe, pad_pullup, pad_schmitt, dbg_pin_in;
	logic avs_waitrequest, boundary_scan_select = 1'b0, dbg_tdo = 1'b0, dbg_tdo_oe = 1'b1;
	logic dbg_swdio_out = 1'b0, dbg_swdio_oe = 1'b0, async_trace_out = 1'b1, erase_lvl = 1'b0;
	logic serial_wire_port_on, scan_mode_on, erase_request, tck, tms;
	int bad_count = 0, check_count = 0;
	always #4 mclk = ~mclk;
	// undriven pads float high by pull-up; board holds erase low at start
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & {erase_lvl, tck, tms, 2'h3});
	dpps_probe u_dpps_probe (.mclk, .tck, .tms);
	dpps_top u_dpps_top (.mclk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .pad_in, .pad_out, .pad_oe, .pad_pullup, .pad_schmitt,
		.boundary_scan_select, .dbg_tdo, .dbg_tdo_oe, .dbg_swdio_out, .dbg_swdio_oe,
		.async_trace_out, .dbg_pin_in, .serial_wire_port_on, .scan_mode_on, .erase_request);
	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !w;
		avs_write <= w;
		do begin
			@(posedge mclk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rdc(input string nm, input logic [3:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(nm, e, q);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic do_reset;
		arst_n <= 1'b0;
		repeat (20) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (3) @(posedge mclk);
	endtask
	task automatic test_reset;
		chk("pullup", 32'h1F, 32'(pad_pullup));
		chk("oe reset", 32'h02, 32'(pad_oe));
		rdc("mode", dpps_pkg::OFS_MODE, 32'h0);
		rdc("pad", dpps_pkg::OFS_PAD, 32'h11111);
		rdc("unmapped", 4'h6, 32'h0);
		chk("dbg in reset", 32'h05, 32'(dbg_pin_in));
		$display("reset test done");
	endtask
	task automatic test_gpio;
		wr(dpps_pkg::OFS_MODE, 32'h2);
		wr(dpps_pkg::OFS_GPIO, 32'h202);
		wr(dpps_pkg::OFS_PAD, 32'h22222);
		repeat (3) @(posedge mclk);
		chk("tdo gpio", 32'h3, 32'({pad_oe[1], pad_out[1]}));
		chk("tdo dbg in", 32'h0, 32'(dbg_pin_in[1]));
		chk("pad set", 32'h1F, 32'({pad_pullup, pad_schmitt}));
		wr(dpps_pkg::OFS_MODE, 32'h0);
		wr(dpps_pkg::OFS_PAD, 32'h11111);
		$display("gpio test done");
	endtask
	task automatic test_switch;
		u_dpps_probe.send(~dpps_pkg::SWITCH_SEQ);
		repeat (8) @(posedge mclk);
		chk("tdo scan", 32'h0, 32'(pad_out[1]));
		chk("swd bad", 32'h0, 32'(serial_wire_port_on));
		u_dpps_probe.send(dpps_pkg::SWITCH_SEQ);
		repeat (8) @(posedge mclk);
		chk("swd", 32'h1, 32'(serial_wire_port_on));
		chk("tdo trace", 32'h1, 32'(pad_out[1]));
		rdc("status swd", dpps_pkg::OFS_STATUS, 32'h1);
		$display("switch test done");
	endtask
	task automatic test_scan;
		boundary_scan_select <= 1'b1;
		repeat (8) @(posedge mclk);
		chk("scan", 32'h2, 32'({scan_mode_on, serial_wire_port_on}));
		rdc("status scan", dpps_pkg::OFS_STATUS, 32'h2);
		boundary_scan_select <= 1'b0;
		repeat (8) @(posedge mclk);
		chk("scan off", 32'h0, 32'(scan_mode_on));
		$display("scan test done");
	endtask
	// tdi looped back through its gpio driver to exercise debounce and glitch filters
	task automatic test_filter;
		wr(dpps_pkg::OFS_PAD, 32'h11114);
		wr(dpps_pkg::OFS_MODE, 32'h1);
		wr(dpps_pkg::OFS_GPIO, 32'h101);
		wr(dpps_pkg::OFS_GPIO, 32'h100);
		wr(dpps_pkg::OFS_GPIO, 32'h101);
		rdc("debounce short", dpps_pkg::OFS_GPIO, 32'h00050101);
		chk("dbg in gpio", 32'h04, 32'(dbg_pin_in));
		wr(dpps_pkg::OFS_GPIO, 32'h100);
		repeat (24) @(posedge mclk);
		rdc("debounce long", dpps_pkg::OFS_GPIO, 32'h00040100);
		wr(dpps_pkg::OFS_PAD, 32'h11118);
		wr(dpps_pkg::OFS_GPIO, 32'h101);
		repeat (8) @(posedge mclk);
		rdc("glitch level", dpps_pkg::OFS_GPIO, 32'h00050101);
		wr(dpps_pkg::OFS_MODE, 32'h0);
		wr(dpps_pkg::OFS_PAD, 32'h11111);
		wr(dpps_pkg::OFS_GPIO, 32'h0);
		$display("filter test done");
	endtask
	task automatic test_erase;
		erase_lvl <= 1'b1;
		do_reset();
		erase_lvl <= 1'b0;
		rdc("status erase", dpps_pkg::OFS_STATUS, 32'h4);
		chk("erase out", 32'h1, 32'(erase_request));
		$display("erase test done");
	endtask
	initial begin
		do_reset();
		test_reset();
		test_gpio();
		test_switch();
		test_scan();
		test_filter();
		test_erase();
		stop_test();
	end
	initial begin
		repeat (6000) @(posedge mclk);
		bad_count++;
		stop_test();
	end
endmodule
